// ### include/canmc_pkg.sv
package canmc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int         ADDR_W          = 6;
	localparam logic [5:0] OFS_MAIN_CTRL   = 6'h00;
	localparam logic [5:0] OFS_SEC_CTRL    = 6'h01;

	// ************************************************************
	// main control field positions
	// ************************************************************
	localparam int BIT_RX_FRAME     = 7;
	localparam int BIT_RX_ACTIVE    = 6;
	localparam int BIT_STOP_IN_WAIT = 5;
	localparam int BIT_BUS_SYNC     = 4;
	localparam int BIT_TIMER_EN     = 3;
	localparam int BIT_WAKE_EN      = 2;
	localparam int BIT_SLEEP_REQ    = 1;
	localparam int BIT_INIT_REQ     = 0;

	// secondary control handshake bits
	localparam int BIT_SLEEP_ACK    = 1;
	localparam int BIT_INIT_ACK     = 0;

	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic       RST_INIT_REQ    = 1'b1;
	localparam logic [3:0] SYNC_RUN_BITS   = 4'hb;
	localparam logic [7:0] SYNC_BUSOFF_RUN = 8'h80;

	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_ABORT  = 2'b01,
		ST_INIT   = 2'b10,
		ST_RESYNC = 2'b11
	} canmc_state_t;

endpackage

// ### src/canmc_mode_control.sv
`timescale 1ns/1ps
module canmc_mode_control (
	input  wire logic                          clock,
	input  wire logic                          rst_b,
	input  wire logic [canmc_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	input  wire logic                          valid_rx_frame,
	input  wire logic                          rx_in_progress,
	input  wire logic                          tx_buffers_empty,
	input  wire logic                          bit_tick,
	input  wire logic                          rx_bit,
	input  wire logic                          bus_off,
	input  wire logic                          valid_eof,
	input  wire logic                          wake_irq_flag,
	input  wire logic                          bus_activity,
	input  wire logic                          cpu_wait,
	input  wire logic                          tx_bit,
	output logic                               transmit_pin,
	output logic                               bus_if_clock_en,
	output logic                               abort_traffic,
	output logic                               init_mode,
	output logic                               config_write_en,
	output logic      [15:0]                   timestamp,
	output logic                               timestamp_write
);

	// ************************************************************
	// state
	// ************************************************************
	canmc_pkg::canmc_state_t state_ff;
	canmc_pkg::canmc_state_t nxt_state;

	logic        rx_frame_ff;
	logic        rx_active_ff;
	logic        stop_in_wait_ff;
	logic        bus_sync_ff;
	logic        timer_en_ff;
	logic        wake_en_ff;
	logic        sleep_req_ff;
	logic        init_req_ff;
	logic        sleep_ack_ff;
	logic [15:0] timer_ff;
	logic [15:0] stamp_ff;
	logic        stamp_wr_ff;
	logic [3:0]  run_ff;
	logic [7:0]  occ_ff;
	logic [7:0]  rdata_ff;

	logic        nxt_rx_frame;
	logic        nxt_stop_in_wait;
	logic        nxt_bus_sync;
	logic        nxt_timer_en;
	logic        nxt_wake_en;
	logic        nxt_sleep_req;
	logic        nxt_init_req;
	logic        nxt_sleep_ack;
	logic [15:0] nxt_timer;
	logic [3:0]  nxt_run;
	logic [7:0]  nxt_occ;

	// ************************************************************
	// decode
	// ************************************************************
	wire         init_ack     = (state_ff == canmc_pkg::ST_INIT);
	wire         in_init      = init_req_ff & init_ack;
	wire         out_of_init  = ~init_req_ff & ~init_ack;
	// hold starts in the abort step, so the register already reads reset when ack shows
	wire         held         = init_req_ff & ((state_ff == canmc_pkg::ST_ABORT) | init_ack);
	wire         wr_main      = reg_wr & (reg_addr == canmc_pkg::OFS_MAIN_CTRL);
	wire         wr_ok        = wr_main & out_of_init;
	wire         rd_main      = reg_rd & (reg_addr == canmc_pkg::OFS_MAIN_CTRL);
	wire         rd_sec       = reg_rd & (reg_addr == canmc_pkg::OFS_SEC_CTRL);
	wire         wake_hit     = sleep_ack_ff & wake_en_ff & bus_activity;
	wire         recessive    = bit_tick & rx_bit;
	wire         run_done     = recessive & (run_ff == canmc_pkg::SYNC_RUN_BITS - 4'h1);
	wire         sync_done    = run_done & (~bus_off
	                          | (occ_ff == canmc_pkg::SYNC_BUSOFF_RUN - 8'h01));

	wire [7:0]   main_byte    = {rx_frame_ff, rx_active_ff, stop_in_wait_ff, bus_sync_ff,
	                             timer_en_ff, wake_en_ff, sleep_req_ff, init_req_ff};
	wire [7:0]   sec_byte     = {6'h00, sleep_ack_ff, init_ack};
	wire [7:0]   nxt_rdata    = rd_main ? main_byte : (rd_sec ? sec_byte : 8'h00);

	// ************************************************************
	// init handshake
	// ************************************************************
	// abort lasts one cycle so traffic is stopped before the acknowledge shows
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			canmc_pkg::ST_RUN: begin
				if (init_req_ff)
					nxt_state = canmc_pkg::ST_ABORT;
			end
			canmc_pkg::ST_ABORT: begin
				nxt_state = canmc_pkg::ST_INIT;
			end
			canmc_pkg::ST_INIT: begin
				if (!init_req_ff)
					nxt_state = canmc_pkg::ST_RESYNC;
			end
			canmc_pkg::ST_RESYNC: begin
				if (init_req_ff)
					nxt_state = canmc_pkg::ST_ABORT;
				else if (sync_done)
					nxt_state = canmc_pkg::ST_RUN;
			end
			default: begin
				nxt_state = canmc_pkg::ST_INIT;
			end
		endcase
	end

	// ************************************************************
	// request bits
	// ************************************************************
	// clear of init request only counts once acknowledged
	assign nxt_init_req = wr_main ? (reg_wdata[canmc_pkg::BIT_INIT_REQ]
	                    | (init_req_ff & ~init_ack)) : init_req_ff;

	// wake-up clear has priority over a software write in the same cycle
	always_comb begin
		nxt_sleep_req = sleep_req_ff;
		if (wake_hit)
			nxt_sleep_req = 1'b0;
		else if (wr_ok)
			nxt_sleep_req = (reg_wdata[canmc_pkg::BIT_SLEEP_REQ] & ~wake_irq_flag)
			              | (sleep_req_ff & ~sleep_ack_ff);
	end

	assign nxt_sleep_ack = sleep_req_ff & ~wake_hit
	                     & (sleep_ack_ff | (~rx_in_progress & tx_buffers_empty));

	assign nxt_wake_en = wr_ok ? reg_wdata[canmc_pkg::BIT_WAKE_EN] : wake_en_ff;

	// ************************************************************
	// bits held at reset in init mode
	// ************************************************************
	// flag set wins over a clearing write in the same cycle
	assign nxt_rx_frame = ~held & (valid_rx_frame
	                    | (rx_frame_ff & ~(wr_ok & reg_wdata[canmc_pkg::BIT_RX_FRAME])));

	assign nxt_stop_in_wait = held ? 1'b0
	                        : (wr_ok ? reg_wdata[canmc_pkg::BIT_STOP_IN_WAIT]
	                        : stop_in_wait_ff);

	assign nxt_timer_en = held ? 1'b0
	                    : (wr_ok ? reg_wdata[canmc_pkg::BIT_TIMER_EN] : timer_en_ff);

	// ************************************************************
	// time stamp timer
	// ************************************************************
	assign nxt_timer = ~timer_en_ff ? 16'h0000
	                 : (bit_tick ? timer_ff + 16'h0001 : timer_ff);

	// ************************************************************
	// resynchronization
	// ************************************************************
	always_comb begin
		nxt_run      = run_ff;
		nxt_occ      = occ_ff;
		nxt_bus_sync = bus_sync_ff;
		if (state_ff != canmc_pkg::ST_RESYNC) begin
			nxt_run = 4'h0;
			nxt_occ = 8'h00;
			if (state_ff != canmc_pkg::ST_RUN)
				nxt_bus_sync = 1'b0;
		end else if (bit_tick && !rx_bit) begin
			nxt_run = 4'h0;
		end else if (run_done) begin
			nxt_run = 4'h0;
			nxt_occ = occ_ff + 8'h01;
			if (sync_done)
				nxt_bus_sync = 1'b1;
		end else if (recessive) begin
			nxt_run = run_ff + 4'h1;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_ff        <= canmc_pkg::ST_INIT;
			init_req_ff     <= canmc_pkg::RST_INIT_REQ;
			sleep_req_ff    <= 1'b0;
			sleep_ack_ff    <= 1'b0;
			wake_en_ff      <= 1'b0;
			rx_frame_ff     <= 1'b0;
			rx_active_ff    <= 1'b0;
			stop_in_wait_ff <= 1'b0;
			bus_sync_ff     <= 1'b0;
			timer_en_ff     <= 1'b0;
		end else begin
			state_ff        <= nxt_state;
			init_req_ff     <= nxt_init_req;
			sleep_req_ff    <= nxt_sleep_req;
			sleep_ack_ff    <= nxt_sleep_ack;
			wake_en_ff      <= nxt_wake_en;
			rx_frame_ff     <= nxt_rx_frame;
			rx_active_ff    <= rx_in_progress & ~held;
			stop_in_wait_ff <= nxt_stop_in_wait;
			bus_sync_ff     <= nxt_bus_sync;
			timer_en_ff     <= nxt_timer_en;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			timer_ff    <= 16'h0000;
			stamp_ff    <= 16'h0000;
			stamp_wr_ff <= 1'b0;
			run_ff      <= 4'h0;
			occ_ff      <= 8'h00;
			rdata_ff    <= 8'h00;
		end else begin
			timer_ff    <= nxt_timer;
			stamp_wr_ff <= valid_eof & timer_en_ff;
			if (valid_eof && timer_en_ff)
				stamp_ff <= timer_ff;
			run_ff      <= nxt_run;
			occ_ff      <= nxt_occ;
			rdata_ff    <= nxt_rdata;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// pin override is combinational so recessive level appears with the request
	assign transmit_pin    = tx_bit | init_req_ff;
	// enable for an external gate cell; logic here keeps its own clock
	assign bus_if_clock_en = ~(stop_in_wait_ff & cpu_wait);
	assign abort_traffic   = (state_ff == canmc_pkg::ST_ABORT) | init_ack;
	assign init_mode       = in_init;
	assign config_write_en = in_init;
	assign timestamp       = stamp_ff;
	assign timestamp_write = stamp_wr_ff;
	assign reg_rdata       = rdata_ff;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_init_req_rise;
		$rose(init_req_ff) && state_ff == canmc_pkg::ST_RUN;
	endsequence

	sequence s_abort_then_ack;
		abort_traffic && !init_ack ##1 init_ack && !bus_sync_ff;
	endsequence

	property p_init_entry;
		s_init_req_rise |=> s_abort_then_ack;
	endproperty
	a_init_entry: assert property (p_init_entry) else $error("init entry wrong");

	property p_init_hold;
		in_init |=> !rx_frame_ff && !timer_en_ff && !stop_in_wait_ff && !rx_active_ff;
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("init hold broken");

	property p_init_clear_blocked;
		init_req_ff && !init_ack && wr_main && !reg_wdata[0] |=> init_req_ff;
	endproperty
	a_init_clear_blocked: assert property (p_init_clear_blocked) else $error("init clr");

	property p_frame_set;
		valid_rx_frame && !held |=> rx_frame_ff;
	endproperty
	a_frame_set: assert property (p_frame_set) else $error("frame flag lost");

	property p_sleep_set_refused;
		wr_ok && wake_irq_flag && !sleep_req_ff |=> !sleep_req_ff;
	endproperty
	a_sleep_set_refused: assert property (p_sleep_set_refused) else $error("sleep set");

	property p_sleep_grant;
		$rose(sleep_ack_ff) |-> $past(!rx_in_progress && tx_buffers_empty && sleep_req_ff);
	endproperty
	a_sleep_grant: assert property (p_sleep_grant) else $error("sleep grant busy");

	property p_wake;
		wake_hit |=> !sleep_req_ff ##1 !sleep_ack_ff;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not honoured");

	property p_timer_off;
		!timer_en_ff |=> timer_ff == 16'h0000;
	endproperty
	a_timer_off: assert property (p_timer_off) else $error("timer not cleared");

	property p_stamp;
		valid_eof && timer_en_ff |=> timestamp_write && timestamp == $past(timer_ff);
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp wrong");

	property p_pin_recessive;
		init_req_ff |-> transmit_pin;
	endproperty
	a_pin_recessive: assert property (p_pin_recessive) else $error("pin driven");

	property p_sync_only_resync;
		$rose(bus_sync_ff) |-> $past(state_ff == canmc_pkg::ST_RESYNC && run_done);
	endproperty
	a_sync_only_resync: assert property (p_sync_only_resync) else $error("sync early");

	property p_init_reset_now;
		in_init |-> !rx_frame_ff && !rx_active_ff && !timer_en_ff
		            && !stop_in_wait_ff && !bus_sync_ff;
	endproperty
	a_init_reset_now: assert property (p_init_reset_now) else $error("init bits set");

	property p_sleep_clr_blocked;
		sleep_req_ff && !sleep_ack_ff && wr_ok && !reg_wdata[canmc_pkg::BIT_SLEEP_REQ]
		|=> sleep_req_ff;
	endproperty
	a_sleep_clr_blocked: assert property (p_sleep_clr_blocked) else $error("slp clr");

	property p_status_ro;
		wr_main && !bus_sync_ff && state_ff != canmc_pkg::ST_RESYNC |=> !bus_sync_ff;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("sync written");

	property p_sleep_ack_set;
		sleep_req_ff && !sleep_ack_ff && !rx_in_progress && tx_buffers_empty
		|=> sleep_ack_ff;
	endproperty
	a_sleep_ack_set: assert property (p_sleep_ack_set) else $error("sleep not acked");

	property p_wake_off;
		sleep_req_ff && sleep_ack_ff && !wake_en_ff && bus_activity && !wr_ok |=> sleep_req_ff;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake while off");

	property p_rx_active;
		!init_req_ff |=> rx_active_ff == $past(rx_in_progress);
	endproperty
	a_rx_active: assert property (p_rx_active) else $error("rx active wrong");

endmodule // canmc_mode_control

// ### sim/canmc_bus_model.sv
`timescale 1ns/1ps
// far side of the bus: bit timing, sampled bus level and wake-up traffic
module canmc_bus_model (
	input  wire logic clock,
	input  wire logic tick_run,
	input  wire logic dominant,
	output logic      bit_tick,
	output logic      rx_bit,
	output logic      bus_activity
);
	logic [1:0] div_ff;

	initial begin
		div_ff = 2'h0;
		bit_tick = 1'b0;
		rx_bit = 1'b1;
	end

	// bit times stand still unless asked for; the line toggles between
	// bits so a stale level never passes for a sampled one
	always @(posedge clock) begin
		div_ff <= div_ff + 2'h1;
		bit_tick <= tick_run && (div_ff == 2'h3);
		rx_bit <= (tick_run && (div_ff == 2'h3)) ? !dominant : !rx_bit;
	end

	assign bus_activity = dominant;
endmodule // canmc_bus_model

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [5:0]  reg_addr = 6'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        valid_rx_frame = 1'b0;
	logic        rx_in_progress = 1'b0;
	logic        tx_buffers_empty = 1'b1;
	logic        bus_off = 1'b0;
	logic        valid_eof = 1'b0;
	logic        wake_irq_flag = 1'b0;
	logic        cpu_wait = 1'b0;
	logic        tx_bit = 1'b0;
	logic        tick_run = 1'b0;
	logic        dominant = 1'b0;
	logic [7:0]  reg_rdata;
	logic [15:0] timestamp;
	logic        bit_tick, rx_bit, bus_activity, transmit_pin, bus_if_clock_en;
	logic        abort_traffic, init_mode, config_write_en, timestamp_write;
	int          bad_count = 0;
	int          compares = 0;
	int          cycles = 0;
	int          tick_cnt = 0;
	int          t0 = 0;

	canmc_bus_model i_bus (.clock, .tick_run, .dominant, .bit_tick, .rx_bit, .bus_activity);

	canmc_mode_control i_dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .valid_rx_frame, .rx_in_progress, .tx_buffers_empty, .bit_tick,
		.rx_bit, .bus_off, .valid_eof, .wake_irq_flag, .bus_activity, .cpu_wait, .tx_bit,
		.transmit_pin, .bus_if_clock_en, .abort_traffic, .init_mode, .config_write_en,
		.timestamp, .timestamp_write);

	always #20 clock = ~clock;

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (bit_tick) tick_cnt <= tick_cnt + 1;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clock) if (cycles == 20000) begin
		bad_count = bad_count + 1;
		wrap_up();
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [15:0] stamp_exp();
		return 16'(tick_cnt - t0);
	endfunction

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [5:0] a, input logic [7:0] e, input string n,
			input logic [7:0] m = 8'hff);
		logic [7:0] d;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata & m;
		chk(n, {8'h00, e & m}, {8'h00, d});
		@(posedge clock);
	endtask

	task automatic ticks(input int n);
		int s;
		s = tick_cnt;
		tick_run <= 1'b1;
		while (tick_cnt < s + n) @(posedge clock);
		tick_run <= 1'b0;
		repeat (8) @(posedge clock);
	endtask

	task automatic eof(input logic [15:0] e, input logic w);
		valid_eof <= 1'b1;
		@(posedge clock);
		valid_eof <= 1'b0;
		#1 chk("stamp strobe", {15'h0, w}, {15'h0, timestamp_write});
		if (w) chk("stamp", e, timestamp);
		@(posedge clock);
	endtask

	task automatic burst(input logic [7:0] dummy);
		dominant <= 1'b1;
		repeat (2) @(posedge clock);
		dominant <= 1'b0;
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		void'($urandom(32'h6874));
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rc(6'h00, 8'h01, "ctrl reset");
		rc(6'h01, 8'h01, "ack reset");
		repeat (6) wr(6'h00, 8'($urandom | 32'h1));
		wr(6'h01, 8'h00);
		rc(6'h00, 8'h01, "ctrl locked");
		rc(6'h01, 8'h01, "status ro");
		rc(6'h3f, 8'h00, "unmapped");
		$display("test init lock done");
		bus_off <= 1'b1;
		wr(6'h00, 8'h00);
		rc(6'h01, 8'h00, "ack drop");
		@(negedge clock);
		chk("pin follows tx", 16'h0, {15'h0, transmit_pin});
		chk("abort off", 16'h0, {15'h0, abort_traffic});
		chk("config shut", 16'h0, {15'h0, config_write_en});
		chk("hold released", 16'h0, {15'h0, init_mode});
		@(posedge clock);
		tx_bit <= 1'b1;
		@(negedge clock);
		chk("pin high", 16'h1, {15'h0, transmit_pin});
		@(posedge clock);
		tx_bit <= 1'b0;
		ticks(1300);
		rc(6'h00, 8'h00, "busoff wait");
		ticks(120);
		rc(6'h00, 8'h10, "busoff sync");
		$display("test resync done");
		wr(6'h00, 8'hfc);
		t0 = tick_cnt;
		rc(6'h00, 8'h3c, "writable");
		cpu_wait <= 1'b1;
		@(negedge clock);
		chk("clock gate", 16'h0, {15'h0, bus_if_clock_en});
		@(posedge clock);
		cpu_wait <= 1'b0;
		@(negedge clock);
		chk("clock runs", 16'h1, {15'h0, bus_if_clock_en});
		@(posedge clock);
		ticks($urandom_range(40, 5));
		eof(stamp_exp(), 1'b1);
		wr(6'h00, 8'h34);
		eof(16'h0, 1'b0);
		wr(6'h00, 8'h3c);
		eof(16'h0, 1'b1);
		valid_rx_frame <= 1'b1;
		@(posedge clock);
		valid_rx_frame <= 1'b0;
		rc(6'h00, 8'hbc, "frame set");
		wr(6'h00, 8'h3c);
		rc(6'h00, 8'hbc, "zero kept");
		wr(6'h00, 8'hbc);
		rc(6'h00, 8'h3c, "one clears");
		$display("test timer and flags done");
		wake_irq_flag <= 1'b1;
		wr(6'h00, 8'h3e);
		rc(6'h00, 8'h3c, "sleep refused", 8'hef);
		wake_irq_flag <= 1'b0;
		rx_in_progress <= 1'b1;
		tx_buffers_empty <= 1'b0;
		wr(6'h00, 8'h3e);
		rc(6'h00, 8'h7e, "rx active", 8'hef);
		rc(6'h01, 8'h00, "busy no ack");
		wr(6'h00, 8'h3c);
		rc(6'h00, 8'h7e, "early clear", 8'hef);
		rx_in_progress <= 1'b0;
		rc(6'h01, 8'h00, "tx full no ack");
		tx_buffers_empty <= 1'b1;
		@(posedge clock);
		rc(6'h01, 8'h02, "sleep ack");
		burst(8'h00);
		rc(6'h00, 8'h3c, "wake clears", 8'hef);
		wr(6'h00, 8'h3a);
		burst(8'h00);
		rc(6'h00, 8'h3a, "wake off", 8'hef);
		rc(6'h01, 8'h02, "still asleep");
		wr(6'h00, 8'h38);
		rc(6'h00, 8'h38, "sw wake", 8'hef);
		$display("test sleep done");
		wr(6'h00, 8'h3d);
		wr(6'h00, 8'h00);
		rc(6'h00, 8'h01, "init hold", 8'hfb);
		@(negedge clock);
		chk("pin recessive", 16'h1, {15'h0, transmit_pin});
		chk("abort", 16'h1, {15'h0, abort_traffic});
		chk("config open", 16'h1, {15'h0, config_write_en});
		chk("hold others", 16'h1, {15'h0, init_mode});
		@(posedge clock);
		rc(6'h01, 8'h01, "init ack");
		bus_off <= 1'b0;
		wr(6'h00, 8'h00);
		ticks(10);
		rc(6'h00, 8'h00, "no sync at ten", 8'hfb);
		ticks(1);
		rc(6'h00, 8'h10, "sync at eleven", 8'hfb);
		$display("test reinit done");
		wrap_up();
	end
endmodule // tb_top
